// ===== include/scrp_pkg.sv
// Operation
// (R1) mode 0 synchronous; modes 1-3 use 7/8/9 bits
// (R2) parity only in modes 1 and 2
// (R3) mode 3 wake-up for multi-controller links
// (R4) three identical channels, each with own registers
// (R5) software never uses divisor 1 in mode 0
// (R6) software leaves baud register alone while busy
// (R7) reading control register clears all error flags
// (R8) software sets prescaler run before using generator
// (R9) data buffer: 8 bits, read receive, write send
// (R10) io_clock_select picks generator or external clock
// (R11) io_clock_select 0: generator output halved
// (R12) io_clock_select 1: external shift clock directly
// (R13) async modes: four clock sources, undivided
// (R14) 4-bit receive counter makes sample clock
// (R15) sync sampling edge set by select bits
// (R16) three samples per bit, majority vote
// (R17) full word moves to readable buffer, interrupt
// (R18) reading readable buffer clears pending flag
// (R19) next frame received while buffer still unread
// (R20) overrun drops new word, keeps buffer, ninth bit
// (R21) ninth bit holds parity or ninth data bit
// (R22) stop bit voted low sets framing error
// (R23) parity mismatch sets parity error flag
// (R24) parity enable and even/odd select bits
// (R25) generator divides chosen tap by 1 to 16
// (R26) start bit detected, counter aligned, centre samples
// (R27) asynchronous data assembled lsb first
package scrp_pkg;
  // register byte addresses
  localparam logic [7:0] SER0_BUF_OFS = 8'h4c;
  localparam logic [7:0] SER1_BUF_OFS = 8'h50;
  localparam logic [7:0] SER2_BUF_OFS = 8'h54;
  localparam logic [7:0] CTRL_BASE = 8'h60;
  localparam logic [7:0] MODE_BASE = 8'h64;
  localparam logic [7:0] BAUD_BASE = 8'h68;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] PRESCALER_OFS = 8'h90;
  // serial_control fields
  localparam int CTRL_IOC = 0;
  localparam int CTRL_EDGE = 1;
  localparam int CTRL_OVR = 2;
  localparam int CTRL_PARITY_ERROR_FLAG = 3;
  localparam int CTRL_FRAMING_ERROR_FLAG = 4;
  localparam int CTRL_EVEN = 5;
  localparam int CTRL_PON = 6;
  localparam int CTRL_NINTH = 7;
  // serial_mode_control fields
  localparam int MODE_SRC_LO = 0;
  localparam int MODE_SEL_LO = 2;
  localparam int MODE_RXEN = 4;
  localparam int MODE_WAKE = 5;
  // baud_generator_control fields
  localparam int BAUD_DIV_LO = 0;
  localparam int BAUD_TAP_LO = 4;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  // receive counter points
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_VOTE = 4'h9;
  localparam logic [3:0] SYNC_LAST_BIT = 4'h7;
  localparam logic [3:0] MAX_FRAME_BITS = 4'h9;
  typedef enum logic [1:0] {MODE_SYNC, MODE_7BIT, MODE_8BIT, MODE_9BIT} scrp_mode_e;
  typedef enum logic [1:0] {SRC_TIMER2, SRC_BAUD, SRC_FC2, SRC_EXT} scrp_src_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} scrp_rx_e;
endpackage

// ===== hdl/scrp_receive_path.sv
module scrp_receive_path #(
  parameter int unsigned CHANNEL = 0
) (
  input wire logic clock, // system clock, 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [7:0] addr, // register byte address
  input wire logic [7:0] wr_data, // register write data
  input wire logic wr_stb, // write strobe
  input wire logic rd_stb, // read strobe
  output logic [7:0] rd_data, // read data, cycle after rd_stb
  input wire logic serial_rx_in, // serial receive line
  input wire logic external_shift_clock, // external shift / serial clock
  input wire logic timer2_match, // timer 2 comparator pulse
  output logic shift_clock_out, // shift clock, driven in mode 0 when io_clock_select is 0
  output logic shift_clock_oe, // high while shift clock is driven
  output logic receive_done_irq, // one-cycle pulse per stored word
  output logic receive_irq_pending, // pending receive request
  output logic [7:0] send_data, // data written for the send side
  output logic send_load // one-cycle pulse on send data write
);
  function automatic logic [7:0] buf_ofs(int unsigned ch);
    if (ch == 1) begin
      return scrp_pkg::SER1_BUF_OFS;
    end else if (ch == 2) begin
      return scrp_pkg::SER2_BUF_OFS;
    end else begin
      return scrp_pkg::SER0_BUF_OFS;
    end
  endfunction

  function automatic logic maj3(logic a, logic b, logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  // each channel instance answers its own addresses and the shared prescaler address
  localparam logic [7:0] CH_OFS = 8'(CHANNEL * scrp_pkg::CH_STRIDE); // (R4)
  localparam logic [7:0] BUF_A = buf_ofs(CHANNEL);
  localparam logic [7:0] CTRL_A = scrp_pkg::CTRL_BASE + CH_OFS;
  localparam logic [7:0] MODE_A = scrp_pkg::MODE_BASE + CH_OFS;
  localparam logic [7:0] BAUD_A = scrp_pkg::BAUD_BASE + CH_OFS;

  logic [7:0] ctrl_q;
  logic [7:0] mode_q;
  logic [7:0] baud_q;
  logic prun_q;
  logic [7:0] pre_q;
  logic [3:0] bg_cnt_q;
  logic half_q;
  logic fc2_q;
  logic ext_q;
  logic [3:0] cnt_q;
  logic [3:0] bits_q;
  logic [8:0] sh_q;
  logic s_a_q;
  logic s_b_q;
  logic pend_q;
  logic [7:0] rxbuf_q;
  scrp_pkg::scrp_rx_e st_q;

  scrp_pkg::scrp_mode_e mode;
  scrp_pkg::scrp_src_e src;
  logic sync_mode;
  logic rx_en;
  logic tap_tick;
  logic bg_tick;
  logic base_tick;
  logic sync_sample;
  logic ext_rise;
  logic ext_fall;
  logic vote;
  logic par_en;
  logic [3:0] nbits;
  logic [8:0] word;
  logic [7:0] fin_byte;
  logic fin;
  logic fin_framing_error_flag;
  logic fin_parity_error_flag;
  logic wake_block;
  logic xfer;
  logic ovr;
  logic rd_ctrl;
  logic rd_buf;

  assign mode = scrp_pkg::scrp_mode_e'(mode_q[scrp_pkg::MODE_SEL_LO +: 2]);
  assign src = scrp_pkg::scrp_src_e'(mode_q[scrp_pkg::MODE_SRC_LO +: 2]);
  assign sync_mode = (mode == scrp_pkg::MODE_SYNC); // (R1)
  assign rx_en = mode_q[scrp_pkg::MODE_RXEN];
  assign rd_ctrl = ce && rd_stb && (addr == CTRL_A);
  assign rd_buf = ce && rd_stb && (addr == BUF_A);

  // shared prescaler; stands still until software sets the run bit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 8'h00;
    end else if (ce && prun_q) begin // (R8)
      pre_q <= pre_q + 8'h01;
    end
  end

  always_comb begin
    case (baud_q[scrp_pkg::BAUD_TAP_LO +: 2]) // (R25)
      2'd0: tap_tick = &pre_q[1:0];
      2'd1: tap_tick = &pre_q[3:0];
      2'd2: tap_tick = &pre_q[5:0];
      default: tap_tick = &pre_q[7:0];
    endcase
    tap_tick = tap_tick && prun_q;
  end

  // divisor field 0 stands for 16: the 4-bit compare wraps to 15
  assign bg_tick = tap_tick && (bg_cnt_q == (baud_q[scrp_pkg::BAUD_DIV_LO +: 4] - 4'h1)); // (R25)

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bg_cnt_q <= 4'h0;
    end else if (ce && tap_tick) begin
      bg_cnt_q <= bg_tick ? 4'h0 : bg_cnt_q + 4'h1;
    end
  end

  // halved generator output doubles as the driven shift clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_q <= 1'b0;
      fc2_q <= 1'b0;
      ext_q <= 1'b0;
    end else if (ce) begin
      if (bg_tick) begin
        half_q <= ~half_q; // (R11)
      end
      fc2_q <= ~fc2_q;
      ext_q <= external_shift_clock;
    end
  end

  assign ext_rise = external_shift_clock && !ext_q;
  assign ext_fall = !external_shift_clock && ext_q;

  always_comb begin
    sync_sample = 1'b0;
    base_tick = 1'b0;
    if (sync_mode) begin
      if (!ctrl_q[scrp_pkg::CTRL_IOC]) begin // (R10)
        sync_sample = bg_tick && !half_q; // (R11) (R15)
      end else begin
        sync_sample = ctrl_q[scrp_pkg::CTRL_EDGE] ? ext_fall : ext_rise; // (R12) (R15)
      end
    end else begin
      case (src) // (R13)
        scrp_pkg::SRC_TIMER2: base_tick = timer2_match;
        scrp_pkg::SRC_BAUD: base_tick = bg_tick;
        scrp_pkg::SRC_FC2: base_tick = fc2_q;
        default: base_tick = ext_rise;
      endcase
    end
  end

  assign par_en = ctrl_q[scrp_pkg::CTRL_PON] &&
                  (mode == scrp_pkg::MODE_7BIT || mode == scrp_pkg::MODE_8BIT); // (R2) (R24)

  always_comb begin
    case (mode) // (R1)
      scrp_pkg::MODE_7BIT: nbits = 4'd7;
      scrp_pkg::MODE_8BIT: nbits = 4'd8;
      default: nbits = 4'd9;
    endcase
    if (par_en) begin
      nbits = nbits + 4'd1;
    end
  end

  assign vote = maj3(s_a_q, s_b_q, serial_rx_in); // (R16)
  // shifted in at the top, so the first bit lands lowest
  assign word = sh_q >> (scrp_pkg::MAX_FRAME_BITS - nbits); // (R27)

  always_comb begin
    fin = 1'b0;
    fin_byte = word[7:0];
    fin_framing_error_flag = 1'b0;
    fin_parity_error_flag = 1'b0;
    wake_block = 1'b0;
    if (sync_mode) begin
      fin = rx_en && sync_sample && (bits_q == scrp_pkg::SYNC_LAST_BIT);
      fin_byte = {serial_rx_in, sh_q[8:2]};
    end else begin
      fin = base_tick && (st_q == scrp_pkg::RX_STOP) && (cnt_q == scrp_pkg::SAMPLE_VOTE);
      fin_framing_error_flag = !vote; // (R22)
      fin_parity_error_flag = par_en && ((^word) == ctrl_q[scrp_pkg::CTRL_EVEN]); // (R23) (R24)
      // in mode 3 with wake-up armed, only frames carrying a set ninth bit get through
      wake_block = (mode == scrp_pkg::MODE_9BIT) && mode_q[scrp_pkg::MODE_WAKE] && !word[8]; // (R3)
    end
  end

  assign xfer = fin && !wake_block && !pend_q; // (R17)
  assign ovr = fin && !wake_block && pend_q; // (R20)

  // asynchronous frame receiver and synchronous shifter share one shift register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= scrp_pkg::RX_IDLE;
      cnt_q <= 4'h0;
      bits_q <= 4'h0;
      sh_q <= 9'h000;
      s_a_q <= 1'b1;
      s_b_q <= 1'b1;
    end else if (ce) begin
      if (!rx_en || (wr_stb && addr == MODE_A)) begin // reprogramming drops any half-counted frame
        st_q <= scrp_pkg::RX_IDLE;
        bits_q <= 4'h0;
      end else if (sync_mode) begin
        st_q <= scrp_pkg::RX_IDLE;
        if (sync_sample) begin
          sh_q <= {serial_rx_in, sh_q[8:1]};
          bits_q <= fin ? 4'h0 : bits_q + 4'h1;
        end
      end else if (base_tick) begin // (R19)
        cnt_q <= cnt_q + 4'h1; // (R14)
        if (cnt_q == scrp_pkg::SAMPLE_A) begin
          s_a_q <= serial_rx_in;
        end
        if (cnt_q == scrp_pkg::SAMPLE_B) begin
          s_b_q <= serial_rx_in;
        end
        case (st_q)
          scrp_pkg::RX_IDLE: begin
            if (!serial_rx_in) begin
              st_q <= scrp_pkg::RX_START; // (R26)
              cnt_q <= 4'h1;
              bits_q <= 4'h0;
            end
          end
          scrp_pkg::RX_START: begin
            if (cnt_q == scrp_pkg::SAMPLE_VOTE) begin
              st_q <= vote ? scrp_pkg::RX_IDLE : scrp_pkg::RX_DATA; // (R26)
            end
          end
          scrp_pkg::RX_DATA: begin
            if (cnt_q == scrp_pkg::SAMPLE_VOTE) begin
              sh_q <= {vote, sh_q[8:1]}; // (R16) (R27)
              bits_q <= bits_q + 4'h1;
              if (bits_q == nbits - 4'h1) begin
                st_q <= scrp_pkg::RX_STOP;
              end
            end
          end
          default: begin
            if (cnt_q == scrp_pkg::SAMPLE_VOTE) begin
              st_q <= scrp_pkg::RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // readable buffer keeps no reset value
  always_ff @(posedge clock) begin
    if (ce && xfer) begin
      rxbuf_q <= fin_byte; // (R9) (R17)
    end
  end

  // a new word wins over a same-cycle read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      receive_done_irq <= 1'b0;
    end else if (ce) begin
      receive_done_irq <= xfer; // (R17)
      if (xfer) begin
        pend_q <= 1'b1;
      end else if (rd_buf) begin
        pend_q <= 1'b0; // (R18)
      end
    end
  end
  assign receive_irq_pending = pend_q;

  // control register: error flags set by hardware, cleared as a group by a read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= scrp_pkg::CTRL_RST;
    end else if (ce) begin
      if (wr_stb && addr == CTRL_A) begin
        ctrl_q[scrp_pkg::CTRL_IOC] <= wr_data[scrp_pkg::CTRL_IOC];
        ctrl_q[scrp_pkg::CTRL_EDGE] <= wr_data[scrp_pkg::CTRL_EDGE];
        ctrl_q[scrp_pkg::CTRL_EVEN] <= wr_data[scrp_pkg::CTRL_EVEN];
        ctrl_q[scrp_pkg::CTRL_PON] <= wr_data[scrp_pkg::CTRL_PON];
      end
      ctrl_q[scrp_pkg::CTRL_OVR] <= ovr || (ctrl_q[scrp_pkg::CTRL_OVR] && !rd_ctrl); // (R7) (R20)
      ctrl_q[scrp_pkg::CTRL_PARITY_ERROR_FLAG] <= (xfer && fin_parity_error_flag) || (ctrl_q[scrp_pkg::CTRL_PARITY_ERROR_FLAG] && !rd_ctrl); // (R7) (R23)
      ctrl_q[scrp_pkg::CTRL_FRAMING_ERROR_FLAG] <= (xfer && fin_framing_error_flag) || (ctrl_q[scrp_pkg::CTRL_FRAMING_ERROR_FLAG] && !rd_ctrl); // (R7) (R22)
      if (xfer && !sync_mode) begin
        // mode 1 parity already sits in bit 7 of the stored byte
        ctrl_q[scrp_pkg::CTRL_NINTH] <= word[8]; // (R21)
      end
    end
  end

  // mode, baud and prescaler registers; divisor 1 in mode 0 is software's to avoid
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= scrp_pkg::MODE_RST;
      baud_q <= scrp_pkg::BAUD_RST;
      prun_q <= 1'b0;
    end else if (ce && wr_stb) begin
      if (addr == MODE_A) begin
        mode_q <= {2'b00, wr_data[5:0]};
      end else if (addr == BAUD_A) begin
        baud_q <= {2'b00, wr_data[5:0]}; // (R25)
      end else if (addr == scrp_pkg::PRESCALER_OFS) begin
        prun_q <= wr_data[0]; // (R8)
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      send_data <= 8'h00;
      send_load <= 1'b0;
    end else if (ce) begin
      send_load <= wr_stb && (addr == BUF_A); // (R9)
      if (wr_stb && addr == BUF_A) begin
        send_data <= wr_data;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shift_clock_out <= 1'b0;
      shift_clock_oe <= 1'b0;
    end else if (ce) begin
      shift_clock_out <= half_q;
      shift_clock_oe <= sync_mode && !ctrl_q[scrp_pkg::CTRL_IOC]; // (R10)
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (ce) begin
      if (!rd_stb) begin
        rd_data <= 8'h00;
      end else if (addr == BUF_A) begin
        rd_data <= rxbuf_q; // (R9)
      end else if (addr == CTRL_A) begin
        rd_data <= ctrl_q;
      end else if (addr == MODE_A) begin
        rd_data <= mode_q;
      end else if (addr == BAUD_A) begin
        rd_data <= baud_q;
      end else if (addr == scrp_pkg::PRESCALER_OFS) begin
        rd_data <= {7'h00, prun_q};
      end else begin
        rd_data <= 8'h00;
      end
    end
  end

  a_err_read_clear: assert property (@(posedge clock) disable iff (!rst_n) // (R7)
    rd_ctrl && !fin |=> ctrl_q[4:2] == 3'b000)
    else $error("error flags not cleared by control read");

  a_buf_read_clear: assert property (@(posedge clock) disable iff (!rst_n) // (R18)
    rd_buf && !xfer |=> !pend_q)
    else $error("pending flag not cleared by buffer read");

  a_overrun_keeps: assert property (@(posedge clock) disable iff (!rst_n) // (R20)
    ce && ovr |=> $stable(rxbuf_q) && ctrl_q[scrp_pkg::CTRL_OVR] && pend_q)
    else $error("overrun did not preserve buffer or set flag");

  a_xfer_raises_irq: assert property (@(posedge clock) disable iff (!rst_n) // (R17)
    ce && xfer |=> pend_q && receive_done_irq && rxbuf_q == $past(fin_byte))
    else $error("transfer did not store word and raise interrupt");

  a_prescaler_gate: assert property (@(posedge clock) disable iff (!rst_n) // (R8)
    !prun_q |-> !bg_tick)
    else $error("baud generator ticks with prescaler stopped");

  a_parity_modes: assert property (@(posedge clock) disable iff (!rst_n) // (R2)
    par_en |-> mode == scrp_pkg::MODE_7BIT || mode == scrp_pkg::MODE_8BIT)
    else $error("parity enabled outside modes 1 and 2");

  a_sync_half_rate: assert property (@(posedge clock) disable iff (!rst_n) // (R11)
    ce && sync_mode && !ctrl_q[scrp_pkg::CTRL_IOC] && sync_sample |=> half_q)
    else $error("sync sample not on rising halved clock");

  a_start_align: assert property (@(posedge clock) disable iff (!rst_n) // (R26)
    ce && rx_en && !(wr_stb && addr == MODE_A) && !sync_mode && base_tick && st_q == scrp_pkg::RX_IDLE
    && !serial_rx_in |=> st_q == scrp_pkg::RX_START && cnt_q == 4'h1)
    else $error("start bit not aligned");

  a_stop_framing: assert property (@(posedge clock) disable iff (!rst_n) // (R22)
    ce && xfer && !sync_mode && !vote |=> ctrl_q[scrp_pkg::CTRL_FRAMING_ERROR_FLAG])
    else $error("low stop bit did not set framing error");
endmodule

// ===== sim/scrp_line_driver.sv
module scrp_line_driver (
  input wire logic clock, // system clock
  output logic line // serial line toward the receiver, idle high
);
  timeunit 1ns;
  timeprecision 1ps;
  // fc/2 source gives a base tick every other cycle, 16 ticks per bit
  localparam int BIT_CYC = 32;

  initial line = 1'b1;

  // frame sender: start, n data bits lsb first, stop held for stop_cyc cycles
  task automatic send(input logic [8:0] bits, input int n, input int stop_cyc, input logic stop_val);
    @(posedge clock);
    line <= 1'b0;
    repeat (BIT_CYC) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      repeat (BIT_CYC) @(posedge clock);
    end
    line <= stop_val;
    repeat (stop_cyc) @(posedge clock);
    // after a short bad stop the low tail opens a new start, which the high line then fails at its start vote
    line <= 1'b1;
    repeat (BIT_CYC) @(posedge clock);
  endtask
endmodule

// ===== sim/test_serial_channel_receive_path.sv
module test_serial_channel_receive_path;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, wr_stb, rd_stb, ext_clk, tb_rx, sync_sel, rx_src, rx_line, timer_tick;
  logic [7:0] addr, wr_data, rd_data, send_data, got;
  logic shift_clock_out, shift_clock_oe, receive_done_irq, receive_irq_pending, send_load;
  int fails, n_tests, n_irq, exp_irq;

  assign rx_line = sync_sel ? tb_rx : rx_src;

  scrp_receive_path #(.CHANNEL(0)) i_scrp_receive_path (
    .clock(clock), .rst_n(rst_n), .ce(1'b1), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .serial_rx_in(rx_line),
    .external_shift_clock(ext_clk), .timer2_match(timer_tick), .shift_clock_out(shift_clock_out),
    .shift_clock_oe(shift_clock_oe), .receive_done_irq(receive_done_irq),
    .receive_irq_pending(receive_irq_pending), .send_data(send_data), .send_load(send_load)
  );
  scrp_line_driver i_scrp_line_driver (.clock(clock), .line(rx_src));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) if (receive_done_irq === 1'b1) n_irq++;

  // timer 2 match every other cycle gives the same bit rate as the fc/2 source
  always @(posedge clock) timer_tick <= ~timer_tick;

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] seen);
    n_tests++;
    if (seen !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic seen);
    n_tests++;
    if (seen !== exp) begin
      $display("FAIL %s expected %b seen %b", name, exp, seen);
      fails++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    @(negedge clock);
    d = rd_data;
  endtask

  // stored word: pending up, one irq pulse each, buffer read returns it and clears pending
  task automatic check_word(input logic [7:0] exp, input int words);
    exp_irq += words;
    chk_bit("pending", 1'b1, receive_irq_pending);
    chk_byte("irq count", 8'(exp_irq), 8'(n_irq));
    rd(scrp_pkg::SER0_BUF_OFS, got);
    chk_byte("buffer", exp, got);
    chk_bit("pending after read", 1'b0, receive_irq_pending);
  endtask

  task automatic test_registers;
    rd(scrp_pkg::CTRL_BASE, got);
    chk_byte("control reset", scrp_pkg::CTRL_RST, got);
    rd(scrp_pkg::MODE_BASE, got);
    chk_byte("mode reset", scrp_pkg::MODE_RST, got);
    rd(scrp_pkg::BAUD_BASE, got);
    chk_byte("baud reset", scrp_pkg::BAUD_RST, got);
    rd(8'h00, got);
    chk_byte("unmapped", 8'h00, got);
    wr(scrp_pkg::MODE_BASE, 8'hff);
    rd(scrp_pkg::MODE_BASE, got);
    chk_byte("mode ro bits", 8'h3f, got);
    wr(scrp_pkg::BAUD_BASE, 8'hff);
    rd(scrp_pkg::BAUD_BASE, got);
    chk_byte("baud ro bits", 8'h3f, got);
    wr(scrp_pkg::SER0_BUF_OFS, 8'h5a);
    @(negedge clock);
    chk_bit("send load", 1'b1, send_load);
    chk_byte("send data", 8'h5a, send_data);
    wr(scrp_pkg::BAUD_BASE, 8'h00);
    wr(scrp_pkg::PRESCALER_OFS, 8'h01);
  endtask

  task automatic test_async_byte;
    wr(scrp_pkg::MODE_BASE, 8'h1a);
    i_scrp_line_driver.send(9'h0a5, 8, 32, 1'b1);
    check_word(8'ha5, 1);
  endtask

  task automatic test_parity;
    wr(scrp_pkg::CTRL_BASE, 8'h60);
    i_scrp_line_driver.send(9'h001, 9, 32, 1'b1);
    rd(scrp_pkg::CTRL_BASE, got);
    chk_byte("parity error set", 8'h68, got);
    rd(scrp_pkg::CTRL_BASE, got);
    chk_byte("flags cleared by read", 8'h60, got);
    check_word(8'h01, 1);
    i_scrp_line_driver.send(9'h003, 9, 32, 1'b1);
    rd(scrp_pkg::CTRL_BASE, got);
    chk_byte("parity good", 8'h60, got);
    check_word(8'h03, 1);
    wr(scrp_pkg::CTRL_BASE, 8'h00);
  endtask

  task automatic test_overrun;
    i_scrp_line_driver.send(9'h03c, 8, 32, 1'b1);
    i_scrp_line_driver.send(9'h0c3, 8, 32, 1'b1);
    rd(scrp_pkg::CTRL_BASE, got);
    chk_byte("overrun flag", 8'h04, got & 8'h7f);
    check_word(8'h3c, 1);
  endtask

  task automatic test_framing;
    i_scrp_line_driver.send(9'h081, 8, 22, 1'b0);
    rd(scrp_pkg::CTRL_BASE, got);
    chk_byte("framing flag", 8'h10, got & 8'h7f);
    check_word(8'h81, 1);
  endtask

  task automatic test_ninth;
    wr(scrp_pkg::MODE_BASE, 8'h1e);
    i_scrp_line_driver.send(9'h196, 9, 32, 1'b1);
    rd(scrp_pkg::CTRL_BASE, got);
    chk_byte("ninth bit", 8'h80, got);
    check_word(8'h96, 1);
  endtask

  // wake-up armed: a frame with the ninth bit clear leaves no trace
  task automatic test_wake;
    wr(scrp_pkg::MODE_BASE, 8'h3e);
    i_scrp_line_driver.send(9'h055, 9, 32, 1'b1);
    chk_bit("wake drop", 1'b0, receive_irq_pending);
    i_scrp_line_driver.send(9'h1aa, 9, 32, 1'b1);
    check_word(8'haa, 1);
  endtask

  // 7-bit frame with odd parity, clocked from timer 2 pulses
  task automatic test_mode1_timer;
    wr(scrp_pkg::CTRL_BASE, 8'h40);
    wr(scrp_pkg::MODE_BASE, 8'h14);
    i_scrp_line_driver.send(9'h0da, 8, 32, 1'b1);
    rd(scrp_pkg::CTRL_BASE, got);
    chk_byte("odd parity good", 8'h40, got);
    check_word(8'hda, 1);
    wr(scrp_pkg::CTRL_BASE, 8'h00);
  endtask

  // mode 0 on the external clock; data held across both edges so either edge may sample
  task automatic test_sync_ext(input logic fall, input logic [7:0] pat);
    wr(scrp_pkg::CTRL_BASE, {6'h00, fall, 1'b1});
    wr(scrp_pkg::MODE_BASE, 8'h10);
    sync_sel <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      tb_rx <= pat[i];
      repeat (2) @(posedge clock);
      ext_clk <= 1'b1;
      repeat (2) @(posedge clock);
      ext_clk <= 1'b0;
      repeat (2) @(posedge clock);
    end
    repeat (4) @(posedge clock);
    chk_bit("shift clock enable", 1'b0, shift_clock_oe);
    check_word(pat, 1);
  endtask

  // mode 0 on the halved generator clock; data moves only after a falling shift clock
  task automatic test_sync_gen(input logic [7:0] pat);
    wr(scrp_pkg::CTRL_BASE, 8'h00);
    sync_sel <= 1'b1;
    @(negedge shift_clock_out);
    wr(scrp_pkg::MODE_BASE, 8'h10);
    for (int i = 0; i < 8; i++) begin
      tb_rx <= pat[i];
      @(negedge shift_clock_out);
    end
    chk_bit("shift clock enable", 1'b1, shift_clock_oe);
    check_word(pat, 1);
    sync_sel <= 1'b0;
  endtask

  task automatic give_verdict;
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    ext_clk = 1'b0;
    tb_rx = 1'b1;
    sync_sel = 1'b0;
    timer_tick = 1'b0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    test_registers();
    test_async_byte();
    test_parity();
    test_overrun();
    test_framing();
    test_ninth();
    test_wake();
    test_mode1_timer();
    test_sync_ext(1'b0, 8'h6b);
    test_sync_ext(1'b1, 8'h94);
    test_sync_gen(8'hc5);
    give_verdict();
  end

  // longest path is about 5,000 cycles of frames, slow shift clock and register traffic
  initial begin
    repeat (30000) @(posedge clock);
    fails++;
    give_verdict();
  end
endmodule
